// ---- core/dcc_defs.vh ----
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define DCC_CNT_BASE      8'h00
`define DCC_STATUS_ADDR   8'h20
`define DCC_IRQ_STAT_ADDR 8'h24
`define DCC_IRQ_MASK_ADDR 8'h28
`define DCC_CHAN_EN_ADDR  8'h2c

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define DCC_CNT_W         10
`define DCC_CNT_RST       10'h000
`define DCC_STATUS_RST    16'h0000
`define DCC_PCOL_LSB      8
`define DCC_RCOL_LSB      0
`define DCC_IRQ_W         2
`define DCC_IRQ_DONE_BIT  0
`define DCC_IRQ_COL_BIT   1

// ****************************************************************
// AXI response codes
// ****************************************************************
`define DCC_RESP_OKAY     2'b00
`define DCC_RESP_SLVERR   2'b10

`endif

// ---- core/dcc_chan_counter.v ----
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Per-channel transfer counter: runs count+1 transfers per block
module dcc_chan_counter #(
  parameter CW = `DCC_CNT_W
) (
  // Clock and reset
  input  wire          core_clk_i,
  input  wire          srst_i,
  // Control
  input  wire          enable_i,
  input  wire [CW-1:0] count_i,
  input  wire          xfer_i,
  // Status
  output reg  [CW-1:0] done_cnt_o,
  output reg           block_done_o
);

  // Counts transfers; the last is the one equal to the count
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      done_cnt_o   <= {CW{1'b0}};
      block_done_o <= 1'b0;
    end else begin
      block_done_o <= 1'b0;
      if (!enable_i) begin
        done_cnt_o <= {CW{1'b0}};
      end else if (xfer_i) begin
        if (done_cnt_o == count_i) begin
          done_cnt_o   <= {CW{1'b0}};
          block_done_o <= 1'b1;
        end else begin
          done_cnt_o <= done_cnt_o + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- core/dcc_top.v ----
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "dcc_defs.vh"

// Transfer count registers and write-collision status over AXI4-Lite
module dcc_top #(
  parameter NCH = 8,
  parameter CW  = `DCC_CNT_W
) (
  // Clock and reset
  input  wire              core_clk_i,
  input  wire              srst_i,
  // AXI4-Lite write address
  input  wire              s_axi_awvalid_i,
  output reg               s_axi_awready_o,
  input  wire [7:0]        s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire              s_axi_wvalid_i,
  output reg               s_axi_wready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  // AXI4-Lite write response
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  output reg  [1:0]        s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire              s_axi_arvalid_i,
  output reg               s_axi_arready_o,
  input  wire [7:0]        s_axi_araddr_i,
  // AXI4-Lite read data
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  // Engine events, one-cycle pulses per channel
  input  wire [NCH-1:0]    xfer_i,
  input  wire [NCH-1:0]    periph_col_i,
  input  wire [NCH-1:0]    ram_col_i,
  // Engine controls and status
  output reg  [NCH-1:0]    chan_en_o,
  output reg  [NCH*CW-1:0] transfer_count_o,
  output reg  [NCH-1:0]    block_done_o,
  output reg               irq_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [CW-1:0]    cnt_reg [0:NCH-1];
  reg  [NCH-1:0]   pcol_reg;
  reg  [NCH-1:0]   xcol_reg;
  reg  [`DCC_IRQ_W-1:0] istat_reg;
  reg  [`DCC_IRQ_W-1:0] imask_reg;
  reg              aw_have_reg;
  reg              w_have_reg;
  reg  [7:0]       awaddr_reg;
  reg  [31:0]      wdata_reg;
  reg  [3:0]       wstrb_reg;
  wire [NCH-1:0]   blk_done;
  wire [NCH*CW-1:0] done_cnt;

  // Write commit once address and data are both held
  wire       wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
  wire       wr_lo  = wr_go && wstrb_reg[0];
  wire       wr_hi  = wr_go && wstrb_reg[1];
  wire       cnt_hit = (awaddr_reg[7:5] == 3'b000);
  wire [2:0] cnt_idx = awaddr_reg[4:2];
  wire       wr_ok  = cnt_hit ||
                      (awaddr_reg[7:2] == `DCC_STATUS_ADDR >> 2) ||
                      (awaddr_reg[7:2] == `DCC_IRQ_STAT_ADDR >> 2) ||
                      (awaddr_reg[7:2] == `DCC_IRQ_MASK_ADDR >> 2) ||
                      (awaddr_reg[7:2] == `DCC_CHAN_EN_ADDR >> 2);

  // ****************************************************************
  // AXI write channels
  // ****************************************************************
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `DCC_RESP_OKAY;
    end else begin
      s_axi_awready_o <= !aw_have_reg && !s_axi_awready_o &&
                         s_axi_awvalid_i;
      s_axi_wready_o  <= !w_have_reg && !s_axi_wready_o &&
                         s_axi_wvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_have_reg    <= 1'b0;
        w_have_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Count registers and collision flags, one slice per channel
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // Ten implemented bits; bits 15-10 never stored
      always @(posedge core_clk_i) begin
        if (srst_i) begin
          cnt_reg[g] <= `DCC_CNT_RST;
        end else if (wr_go && cnt_hit && cnt_idx == g) begin
          if (wr_lo)
            cnt_reg[g][7:0] <= wdata_reg[7:0];
          if (wr_hi)
            cnt_reg[g][CW-1:8] <= wdata_reg[CW-1:8];
        end
      end

      // Hardware sets, write-one clears, set wins
      always @(posedge core_clk_i) begin
        if (srst_i) begin
          pcol_reg[g] <= 1'b0;
          xcol_reg[g] <= 1'b0;
        end else begin
          if (periph_col_i[g])
            pcol_reg[g] <= 1'b1;
          else if (wr_hi && awaddr_reg == `DCC_STATUS_ADDR &&
                   wdata_reg[`DCC_PCOL_LSB + g])
            pcol_reg[g] <= 1'b0;
          if (ram_col_i[g])
            xcol_reg[g] <= 1'b1;
          else if (wr_lo && awaddr_reg == `DCC_STATUS_ADDR &&
                   wdata_reg[`DCC_RCOL_LSB + g])
            xcol_reg[g] <= 1'b0;
        end
      end

      dcc_chan_counter #(
        .CW (CW)
      ) u_cnt (
        .core_clk_i   (core_clk_i),
        .srst_i       (srst_i),
        .enable_i     (chan_en_o[g]),
        .count_i      (cnt_reg[g]),
        .xfer_i       (xfer_i[g]),
        .done_cnt_o   (done_cnt[g*CW +: CW]),
        .block_done_o (blk_done[g])
      );

      // Count handed to the engine from a flop
      always @(posedge core_clk_i) begin
        if (srst_i)
          transfer_count_o[g*CW +: CW] <= `DCC_CNT_RST;
        else
          transfer_count_o[g*CW +: CW] <= cnt_reg[g];
      end
    end
  endgenerate

  // ****************************************************************
  // Channel enable and interrupt registers
  // ****************************************************************
  wire ev_done = |blk_done;
  wire ev_col  = |periph_col_i | |ram_col_i;
  wire wr_ist  = wr_lo && awaddr_reg == `DCC_IRQ_STAT_ADDR;

  // Enables steer counters; sticky events, W1C, set wins
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      chan_en_o    <= {NCH{1'b0}};
      imask_reg    <= {`DCC_IRQ_W{1'b0}};
      istat_reg    <= {`DCC_IRQ_W{1'b0}};
      block_done_o <= {NCH{1'b0}};
      irq_o        <= 1'b0;
    end else begin
      block_done_o <= blk_done;
      if (wr_lo && awaddr_reg == `DCC_CHAN_EN_ADDR)
        chan_en_o <= wdata_reg[NCH-1:0];
      if (wr_lo && awaddr_reg == `DCC_IRQ_MASK_ADDR)
        imask_reg <= wdata_reg[`DCC_IRQ_W-1:0];
      if (ev_done)
        istat_reg[`DCC_IRQ_DONE_BIT] <= 1'b1;
      else if (wr_ist && wdata_reg[`DCC_IRQ_DONE_BIT])
        istat_reg[`DCC_IRQ_DONE_BIT] <= 1'b0;
      if (ev_col)
        istat_reg[`DCC_IRQ_COL_BIT] <= 1'b1;
      else if (wr_ist && wdata_reg[`DCC_IRQ_COL_BIT])
        istat_reg[`DCC_IRQ_COL_BIT] <= 1'b0;
      irq_o <= |(istat_reg & imask_reg);
    end
  end

  // ****************************************************************
  // AXI read channel
  // ****************************************************************
  reg [31:0] rd_mux;
  reg        rd_ok;

  // Read decode; unimplemented bits read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr_i[7:5] == 3'b000)
      rd_mux[CW-1:0] = cnt_reg[s_axi_araddr_i[4:2]];
    else if (s_axi_araddr_i[7:2] == `DCC_STATUS_ADDR >> 2)
      rd_mux[15:0] = {pcol_reg, xcol_reg};
    else if (s_axi_araddr_i[7:2] == `DCC_IRQ_STAT_ADDR >> 2)
      rd_mux[`DCC_IRQ_W-1:0] = istat_reg;
    else if (s_axi_araddr_i[7:2] == `DCC_IRQ_MASK_ADDR >> 2)
      rd_mux[`DCC_IRQ_W-1:0] = imask_reg;
    else if (s_axi_araddr_i[7:2] == `DCC_CHAN_EN_ADDR >> 2)
      rd_mux[NCH-1:0] = chan_en_o;
    else
      rd_ok = 1'b0;
  end

  // Single outstanding read, answered the cycle after acceptance
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= `DCC_RESP_OKAY;
    end else begin
      s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o &&
                         !s_axi_rvalid_o;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_mux;
        s_axi_rresp_o  <= rd_ok ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

endmodule

// ---- verif/dcc_props.sv ----
`timescale 1ns/1ps
// Bus handshake and status checks on the top ports
module dcc_props #(
  parameter NCH = 8,
  parameter CW  = 10
) (
  // Clock and reset
  input wire              core_clk_i,
  input wire              srst_i,
  // Bus handshakes
  input wire              s_axi_awvalid_i,
  input wire              s_axi_awready_o,
  input wire              s_axi_wvalid_i,
  input wire              s_axi_wready_o,
  input wire              s_axi_bvalid_o,
  input wire              s_axi_bready_i,
  input wire [1:0]        s_axi_bresp_o,
  input wire              s_axi_arvalid_i,
  input wire              s_axi_arready_o,
  input wire              s_axi_rvalid_o,
  input wire              s_axi_rready_i,
  input wire [31:0]       s_axi_rdata_o,
  // Engine side
  input wire [NCH-1:0]    chan_en_o,
  input wire [NCH*CW-1:0] transfer_count_o,
  input wire              irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Address and data taken at one edge
  sequence aw_w_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence b_waiting;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence
  a_b_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid_o)
    else $error("write response missing");
  a_b_hold: assert property (b_waiting |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_ar_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read data missing");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata moved");
  a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read accepted while busy");
  a_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("awready held");
  a_reset_clear: assert property ($fell(srst_i) |-> transfer_count_o == 0
    && chan_en_o == 0 && !irq_o) else $error("outputs not cleared");
  a_irq_sticky: assert property (irq_o && !s_axi_wvalid_i
    && !s_axi_bvalid_o |=> irq_o) else $error("irq fell without write");
endmodule

bind dcc_top dcc_props #(.NCH(NCH), .CW(CW)) u_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .chan_en_o(chan_en_o), .transfer_count_o(transfer_count_o),
  .irq_o(irq_o));

// ---- verif/dcc_eng_model.sv ----
`timescale 1ns/1ps
// Engine stand-in: slow transfer pulses and collision events
module dcc_eng_model (
  // Clock
  input  wire       core_clk_i,
  // Controls
  input  wire [7:0] chan_en_i,
  input  wire       run_i,
  input  wire [7:0] pcol_i,
  input  wire [7:0] rcol_i,
  // Events
  output reg  [7:0] xfer_o = 8'h00,
  output reg  [7:0] periph_col_o = 8'h00,
  output reg  [7:0] ram_col_o = 8'h00
);
  reg [1:0] ph_reg = 2'h0;
  // One transfer per enabled channel every fourth cycle
  always @(posedge core_clk_i) begin
    ph_reg       <= ph_reg + 2'h1;
    xfer_o       <= (run_i && ph_reg == 2'h0) ? chan_en_i : 8'h00;
    periph_col_o <= pcol_i;
    ram_col_o    <= rcol_i;
  end
endmodule

// ---- verif/test_dcc_top.sv ----
`timescale 1ns/1ps
module test_dcc_top;
  reg        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  reg        run = 0;
  reg  [7:0] awa = 0, ara = 0, pc = 0, rc = 0, got = 0;
  reg [31:0] wd = 0;
  reg  [3:0] ws = 0;
  wire       awr, wrdy, bv, arr, rv, irq;
  wire [1:0] br, rr;
  wire [31:0] rd_w;
  wire [7:0] en, xf, pco, rco, bd;
  wire [79:0] tc;
  int        errors = 0, n_checks = 0, i, k, t, cnt[8], snap[8];
  always #2.5 clk = ~clk;
  dcc_top u_dut (.core_clk_i(clk), .srst_i(rst), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd_w),
    .s_axi_rresp_o(rr), .xfer_i(xf), .periph_col_i(pco), .ram_col_i(rco),
    .chan_en_o(en), .transfer_count_o(tc), .block_done_o(bd), .irq_o(irq));
  dcc_eng_model u_eng (.core_clk_i(clk), .chan_en_i(en), .run_i(run),
    .pcol_i(pc), .rcol_i(rc), .xfer_o(xf), .periph_col_o(pco),
    .ram_col_o(rco));
  // Count transfers per channel up to its first block end
  always @(posedge clk) for (k = 0; k < 8; k++) begin
    if (bd[k] && !got[k]) begin
      snap[k] <= cnt[k];
      got[k]  <= 1'b1;
    end
    if (en[k]) cnt[k] <= cnt[k] + xf[k];
  end
  task results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tmo(input int lim);
    if (t >= lim) begin
      errors++;
      $display("[ERR] wait expected handshake seen timeout");
      results;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] eb);
    @(posedge clk);
    awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1; t = 0;
    do begin
      @(posedge clk);
      t++;
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv && t < 99);
    bry <= 0;
    chk("bresp", eb, br);
    tmo(99);
  endtask
  task rd(input [7:0] a, input [31:0] e, input [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1; t = 0;
    do begin
      @(posedge clk);
      t++;
      if (arr) arv <= 0;
    end while (!rv && t < 99);
    rry <= 0;
    chk("rdata", e, rd_w);
    chk("rresp", er, rr);
    tmo(99);
  endtask
  initial begin
    for (k = 0; k < 8; k++) cnt[k] = 0;
    repeat (8) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 8; i++) rd(4 * i, 0, 0);
    rd(8'h20, 0, 0);
    $display("test reset done");
    for (i = 0; i < 8; i++) wr(4 * i, ~(i * 113), 4'hf, 0);
    for (i = 0; i < 8; i++) begin
      rd(4 * i, ~(i * 113) & 32'h3ff, 0);
      chk("count_out", ~(i * 113) & 32'h3ff, tc[10 * i +: 10]);
    end
    wr(8'h04, 0, 4'h1, 0);
    rd(8'h04, 32'h300, 0);
    wr(8'h04, 0, 4'hf, 0);
    $display("test count done");
    wr(8'h2c, 8'h07, 4'hf, 0);
    run <= 1;
    for (t = 0; t < 5000 && got[2:0] !== 3'h7; t++) @(posedge clk);
    tmo(5000);
    run <= 0;
    wr(8'h2c, 0, 4'hf, 0);
    chk("xfers0", 1024, snap[0]);
    chk("xfers1", 1, snap[1]);
    chk("xfers2", 798, snap[2]);
    $display("test transfers done");
    wr(8'h24, 3, 4'hf, 0);
    pc <= 8'h08; rc <= 8'h20;
    @(posedge clk);
    pc <= 0; rc <= 0;
    repeat (3) @(posedge clk);
    rd(8'h20, 32'h0820, 0);
    chk("irq", 0, irq);
    rd(8'h24, 2, 0);
    wr(8'h28, 2, 4'hf, 0);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wr(8'h20, 32'hf7df, 4'h3, 0);
    rd(8'h20, 32'h0820, 0);
    wr(8'h20, 32'h0800, 4'h3, 0);
    rd(8'h20, 32'h0020, 0);
    rc <= 8'h20;
    wr(8'h20, 32'h0020, 4'h3, 0);
    rc <= 0;
    rd(8'h20, 32'h0020, 0);
    wr(8'h20, 32'h0020, 4'h3, 0);
    rd(8'h20, 0, 0);
    chk("irq", 1, irq);
    wr(8'h24, 3, 4'hf, 0);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    $display("test collision done");
    wr(8'h30, 1, 4'hf, 2'b10);
    rd(8'h30, 0, 2'b10);
    $display("test unmapped done");
    results;
  end
endmodule
